// ---- adc_cal_pkg.sv ----
// constants shared by the gain, rate and calibration register block
package adc_cal_pkg;

    // ****************************************
    // bus geometry
    // ****************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int IDX_LSB = 2;
    localparam int IDX_W = 6;

    // ****************************************
    // register indices, byte address is four times the index
    // ****************************************
    localparam logic [5:0] IDX_GAIN_RATE = 6'h03;
    localparam logic [5:0] IDX_OFFSET_0 = 6'h04;
    localparam logic [5:0] IDX_OFFSET_1 = 6'h05;
    localparam logic [5:0] IDX_OFFSET_2 = 6'h06;
    localparam logic [5:0] IDX_FULLSCALE_0 = 6'h07;
    localparam logic [5:0] IDX_FULLSCALE_1 = 6'h08;
    localparam logic [5:0] IDX_FULLSCALE_2 = 6'h09;
    localparam logic [5:0] IDX_EXCITATION = 6'h0A;
    localparam logic [5:0] IDX_MONITOR = 6'h10;
    localparam logic [5:0] IDX_READOUT = 6'h11;
    localparam logic [5:0] IDX_RESULT = 6'h12;

    // ****************************************
    // field layout and reset values
    // ****************************************
    localparam int GAIN_LSB = 4;
    localparam int RATE_LSB = 0;
    localparam int MODE_BIT = 3;
    localparam int MAG_LSB = 0;
    localparam int REV_LSB = 4;
    localparam logic [6:0] GAIN_RATE_RST = 7'h00;
    localparam logic [23:0] OFFSET_RST = 24'h000000;
    localparam logic [23:0] FULLSCALE_RST = 24'h400000;
    localparam logic [3:0] EXC_LOW_RST = 4'h0;
    localparam logic [2:0] MONITOR_RST = 3'h0;
    localparam logic [2:0] MONITOR_NORMAL = 3'h0;
    localparam logic [2:0] MONITOR_OFFSET = 3'h1;
    localparam logic [2:0] GAIN_UNITY = 3'h0;
    localparam logic CONT_RST = 1'b1;

    // ****************************************
    // datapath
    // ****************************************
    localparam int RAW_W = 16;
    localparam int FRAC_W = 8;
    localparam int CAL_W = 24;
    localparam int UNITY_SHIFT = 22;
    localparam logic signed [15:0] OUT_MAX = 16'sh7FFF;
    localparam logic signed [15:0] OUT_MIN = -16'sh8000;

    // ****************************************
    // bus answers
    // ****************************************
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ---- adc_cal_datapath.sv ----
// offset subtraction, full-scale scaling and saturation of each raw result
`timescale 1ns/1ps
`default_nettype none
module adc_cal_datapath (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clkEn,
    input wire logic rawValid,
    input wire logic [15:0] rawData,
    input wire logic [23:0] offsetWord,
    input wire logic [23:0] fullscaleWord,
    output logic resultValid,
    output logic [15:0] resultData,
    output logic resultClipped
);
    logic signed [25:0] diff_q;
    logic diffValid_q;
    logic signed [25:0] rawExt;
    logic signed [50:0] product;
    logic signed [50:0] scaled;

    // ****************************************
    // stage one: raw word gains eight fraction bits, offset removed
    // ****************************************
    assign rawExt = 26'(signed'({rawData, {adc_cal_pkg::FRAC_W{1'b0}}}));

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            diff_q <= '0;
            diffValid_q <= 1'b0;
        end else if (clkEn) begin
            diffValid_q <= rawValid;
            if (rawValid) begin
                diff_q <= rawExt - 26'(signed'(offsetWord));
            end
        end
    end

    // ****************************************
    // stage two: multiply by word over unity, then clip
    // ****************************************
    // wide product so neither step can wrap before the clip
    assign product = 51'(diff_q) * 51'(signed'({1'b0, fullscaleWord}));
    assign scaled = product >>> (adc_cal_pkg::UNITY_SHIFT + adc_cal_pkg::FRAC_W);

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            resultValid <= 1'b0;
            resultData <= '0;
            resultClipped <= 1'b0;
        end else if (clkEn) begin
            resultValid <= diffValid_q;
            if (diffValid_q) begin
                if (scaled > 51'(adc_cal_pkg::OUT_MAX)) begin
                    resultData <= adc_cal_pkg::OUT_MAX;
                    resultClipped <= 1'b1;
                end else if (scaled < 51'(adc_cal_pkg::OUT_MIN)) begin
                    resultData <= adc_cal_pkg::OUT_MIN;
                    resultClipped <= 1'b1;
                end else begin
                    resultData <= scaled[15:0];
                    resultClipped <= 1'b0;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ---- adc_gain_rate_calibration_regs.sv ----
// gain, rate and calibration registers with serial result readout
//
// Function
// - top gain/rate bit reads zero, host writes zero
// - gain field selects two to the code
// - rate field selects sample rate, high codes 2000
// - offset word built from three bytes, low first
// - offset upper sixteen bits whole, low byte fraction
// - offset subtracted before full-scale scaling
// - full-scale word unsigned, resets to unity
// - result multiplied by word over unity
// - revision field read-only, may change
// - mode bit adds ready flag to combined pin while the readout bit is set
// - dedicated ready pin always signals new data
// - magnitude field selects excitation current
// - monitor selections other than normal and offset force unity gain
`timescale 1ns/1ps
`default_nettype none
module adc_gain_rate_calibration_regs #(
    parameter logic [3:0] REVISION = 4'h5 // arbitrary value
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clkEn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic rawValid,
    input wire logic [15:0] rawData,
    input wire logic serialClk,
    input wire logic chipSelB,
    output logic combinedOut,
    output logic dataReadyB,
    output logic [2:0] gainSelect,
    output logic [7:0] gainFactor,
    output logic [3:0] rateSelect,
    output logic [11:0] rateSps,
    output logic [2:0] excitationMagnitude,
    output logic [10:0] excitationMicroAmp,
    output logic [2:0] monitorSelect
);

    // ****************************************
    // decoders
    // ****************************************
    function automatic logic isMapped(input logic [5:0] idx);
        isMapped = (idx >= adc_cal_pkg::IDX_GAIN_RATE && idx <= adc_cal_pkg::IDX_EXCITATION)
            || (idx >= adc_cal_pkg::IDX_MONITOR && idx <= adc_cal_pkg::IDX_RESULT);
    endfunction

    function automatic logic [11:0] rateOf(input logic [3:0] code);
        case (code)
            4'h0: rateOf = 12'd5;
            4'h1: rateOf = 12'd10;
            4'h2: rateOf = 12'd20;
            4'h3: rateOf = 12'd40;
            4'h4: rateOf = 12'd80;
            4'h5: rateOf = 12'd160;
            4'h6: rateOf = 12'd320;
            4'h7: rateOf = 12'd640;
            4'h8: rateOf = 12'd1000;
            default: rateOf = 12'd2000;
        endcase
    endfunction

    function automatic logic [10:0] currentOf(input logic [2:0] code);
        case (code)
            3'h1: currentOf = 11'd50;
            3'h2: currentOf = 11'd100;
            3'h3: currentOf = 11'd250;
            3'h4: currentOf = 11'd500;
            3'h5: currentOf = 11'd750;
            3'h7: currentOf = 11'd1500;
            // code 110 is undefined, kept off
            default: currentOf = 11'd0;
        endcase
    endfunction

    // ****************************************
    // register storage
    // ****************************************
    logic [6:0] gainRate_q;
    logic [23:0] offset_q;
    logic [23:0] fullscale_q;
    logic [3:0] excLow_q;
    logic [2:0] monitor_q;
    logic contReadout_q;

    logic awHeld_q, wHeld_q;
    logic [5:0] awIdx_q;
    logic [31:0] wData_q;
    logic wLane0_q;
    logic doWrite;
    logic [5:0] rdIdx;
    logic [31:0] rdValue;

    logic resultValid;
    logic [15:0] resultData;
    logic resultClipped;
    logic [15:0] resultHold_q;
    logic clipHold_q;

    // ****************************************
    // write channel
    // ****************************************
    // one write in flight: address and data wait until the response drains
    assign s_axi_awready = !awHeld_q && !s_axi_bvalid;
    assign s_axi_wready = !wHeld_q && !s_axi_bvalid;
    assign doWrite = awHeld_q && wHeld_q && !s_axi_bvalid;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            awHeld_q <= 1'b0;
            awIdx_q <= '0;
        end else if (clkEn) begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_q <= 1'b1;
                awIdx_q <= s_axi_awaddr[adc_cal_pkg::IDX_LSB +: adc_cal_pkg::IDX_W];
            end else if (doWrite) begin
                awHeld_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wHeld_q <= 1'b0;
            wData_q <= '0;
            wLane0_q <= 1'b0;
        end else if (clkEn) begin
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wLane0_q <= s_axi_wstrb[0];
            end else if (doWrite) begin
                wHeld_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= adc_cal_pkg::RESP_OKAY;
        end else if (clkEn) begin
            if (doWrite) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= isMapped(awIdx_q) ? adc_cal_pkg::RESP_OKAY : adc_cal_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ****************************************
    // register updates
    // ****************************************
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            gainRate_q <= adc_cal_pkg::GAIN_RATE_RST;
            offset_q <= adc_cal_pkg::OFFSET_RST;
            fullscale_q <= adc_cal_pkg::FULLSCALE_RST;
            excLow_q <= adc_cal_pkg::EXC_LOW_RST;
            monitor_q <= adc_cal_pkg::MONITOR_RST;
            contReadout_q <= adc_cal_pkg::CONT_RST;
        end else if (clkEn && doWrite && wLane0_q) begin
            case (awIdx_q)
                adc_cal_pkg::IDX_GAIN_RATE: gainRate_q <= wData_q[6:0];
                adc_cal_pkg::IDX_OFFSET_0: offset_q[7:0] <= wData_q[7:0];
                adc_cal_pkg::IDX_OFFSET_1: offset_q[15:8] <= wData_q[7:0];
                adc_cal_pkg::IDX_OFFSET_2: offset_q[23:16] <= wData_q[7:0];
                adc_cal_pkg::IDX_FULLSCALE_0: fullscale_q[7:0] <= wData_q[7:0];
                adc_cal_pkg::IDX_FULLSCALE_1: fullscale_q[15:8] <= wData_q[7:0];
                adc_cal_pkg::IDX_FULLSCALE_2: fullscale_q[23:16] <= wData_q[7:0];
                adc_cal_pkg::IDX_EXCITATION: excLow_q <= wData_q[3:0];
                adc_cal_pkg::IDX_MONITOR: monitor_q <= wData_q[2:0];
                adc_cal_pkg::IDX_READOUT: contReadout_q <= wData_q[0];
                default: begin
                end
            endcase
        end
    end

    // ****************************************
    // read channel
    // ****************************************
    assign s_axi_arready = !s_axi_rvalid;
    assign rdIdx = s_axi_araddr[adc_cal_pkg::IDX_LSB +: adc_cal_pkg::IDX_W];

    always_comb begin
        rdValue = '0;
        case (rdIdx)
            adc_cal_pkg::IDX_GAIN_RATE: rdValue[6:0] = gainRate_q;
            adc_cal_pkg::IDX_OFFSET_0: rdValue[7:0] = offset_q[7:0];
            adc_cal_pkg::IDX_OFFSET_1: rdValue[7:0] = offset_q[15:8];
            adc_cal_pkg::IDX_OFFSET_2: rdValue[7:0] = offset_q[23:16];
            adc_cal_pkg::IDX_FULLSCALE_0: rdValue[7:0] = fullscale_q[7:0];
            adc_cal_pkg::IDX_FULLSCALE_1: rdValue[7:0] = fullscale_q[15:8];
            adc_cal_pkg::IDX_FULLSCALE_2: rdValue[7:0] = fullscale_q[23:16];
            adc_cal_pkg::IDX_EXCITATION: rdValue[7:0] = {REVISION, excLow_q};
            adc_cal_pkg::IDX_MONITOR: rdValue[2:0] = monitor_q;
            adc_cal_pkg::IDX_READOUT: rdValue[0] = contReadout_q;
            adc_cal_pkg::IDX_RESULT: rdValue[16:0] = {clipHold_q, resultHold_q};
            default: rdValue = '0;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= adc_cal_pkg::RESP_OKAY;
        end else if (clkEn) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rdValue;
                s_axi_rresp <= isMapped(rdIdx) ? adc_cal_pkg::RESP_OKAY : adc_cal_pkg::RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ****************************************
    // analog settings
    // ****************************************
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            gainSelect <= adc_cal_pkg::GAIN_UNITY;
            gainFactor <= 8'h01;
            rateSelect <= '0;
            rateSps <= rateOf(4'h0);
            excitationMagnitude <= '0;
            excitationMicroAmp <= '0;
            monitorSelect <= adc_cal_pkg::MONITOR_RST;
        end else if (clkEn) begin
            // stored gain field is kept, only the applied gain is forced
            if (monitor_q == adc_cal_pkg::MONITOR_NORMAL || monitor_q == adc_cal_pkg::MONITOR_OFFSET) begin
                gainSelect <= gainRate_q[adc_cal_pkg::GAIN_LSB +: 3];
                gainFactor <= 8'h01 << gainRate_q[adc_cal_pkg::GAIN_LSB +: 3];
            end else begin
                gainSelect <= adc_cal_pkg::GAIN_UNITY;
                gainFactor <= 8'h01;
            end
            rateSelect <= gainRate_q[adc_cal_pkg::RATE_LSB +: 4];
            rateSps <= rateOf(gainRate_q[adc_cal_pkg::RATE_LSB +: 4]);
            excitationMagnitude <= excLow_q[adc_cal_pkg::MAG_LSB +: 3];
            // no check on the reference here, that stays with software
            excitationMicroAmp <= currentOf(excLow_q[adc_cal_pkg::MAG_LSB +: 3]);
            monitorSelect <= monitor_q;
        end
    end

    // ****************************************
    // calibration datapath
    // ****************************************
    adc_cal_datapath calPath (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .clkEn(clkEn),
        .rawValid(rawValid),
        .rawData(rawData),
        .offsetWord(offset_q),
        .fullscaleWord(fullscale_q),
        .resultValid(resultValid),
        .resultData(resultData),
        .resultClipped(resultClipped)
    );

    // ****************************************
    // serial readout
    // ****************************************
    logic sclkMeta_q, sclkSync_q, sclkPrev_q;
    logic csMeta_q, csSync_q, csPrev_q;
    logic csFall, sclkFall;
    logic [15:0] shift_q;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sclkMeta_q <= 1'b0;
            sclkSync_q <= 1'b0;
            sclkPrev_q <= 1'b0;
            csMeta_q <= 1'b1;
            csSync_q <= 1'b1;
            csPrev_q <= 1'b1;
        end else if (clkEn) begin
            sclkMeta_q <= serialClk;
            sclkSync_q <= sclkMeta_q;
            sclkPrev_q <= sclkSync_q;
            csMeta_q <= chipSelB;
            csSync_q <= csMeta_q;
            csPrev_q <= csSync_q;
        end
    end

    assign csFall = csPrev_q && !csSync_q;
    assign sclkFall = sclkPrev_q && !sclkSync_q && !csSync_q;

    // a transfer in progress keeps its word, a newer one waits
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            resultHold_q <= '0;
            clipHold_q <= 1'b0;
        end else if (clkEn && resultValid) begin
            resultHold_q <= resultData;
            clipHold_q <= resultClipped;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            shift_q <= '0;
        end else if (clkEn) begin
            if (csFall) begin
                shift_q <= resultHold_q;
            end else if (sclkFall) begin
                shift_q <= {shift_q[14:0], 1'b0};
            end
        end
    end

    // new data wins over the clear by a transfer start
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            dataReadyB <= 1'b1;
        end else if (clkEn) begin
            if (resultValid) begin
                dataReadyB <= 1'b0;
            end else if (csFall) begin
                dataReadyB <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            combinedOut <= 1'b1;
        end else if (clkEn) begin
            if (!csSync_q) begin
                combinedOut <= shift_q[15];
            end else if (gainRateModeOn()) begin
                combinedOut <= dataReadyB;
            end else begin
                combinedOut <= 1'b1;
            end
        end
    end

    function automatic logic gainRateModeOn();
        gainRateModeOn = excLow_q[adc_cal_pkg::MODE_BIT] && contReadout_q;
    endfunction

endmodule
`default_nettype wire

// ---- adc_cal_monitor.sv ----
// assertion checker for the gain, rate and calibration register block
`timescale 1ns/1ps
`default_nettype none
module adc_cal_monitor (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic chipSelB,
    input wire logic combinedOut,
    input wire logic dataReadyB,
    input wire logic [2:0] gainSelect,
    input wire logic [7:0] gainFactor,
    input wire logic [3:0] rateSelect,
    input wire logic [11:0] rateSps,
    input wire logic [2:0] monitorSelect
);
    // ****************************************
    // properties
    // ****************************************
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // stable guards allow one cycle of lag between code and decoded output
    a_gain_power: assert property ($stable(gainSelect) |-> gainFactor == (8'h01 << gainSelect))
        else $error("gain factor mismatch");
    a_rate_table: assert property ($stable(rateSelect) |-> rateSps ==
        (rateSelect[3] ? ((|rateSelect[2:0]) ? 12'h7D0 : 12'h3E8) : 12'h005 << rateSelect[2:0]))
        else $error("rate mismatch");
    a_gain_forced: assert property (monitorSelect > 3'h1 && $stable(monitorSelect) |-> gainSelect == 3'h0)
        else $error("gain not forced");
    a_ready_pin_holds: assert property ((!dataReadyB && chipSelB) [*4] |=> !dataReadyB)
        else $error("ready pin dropped early");
    a_idle_high: assert property (chipSelB [*8] ##0 dataReadyB [*2] |-> combinedOut)
        else $error("combined pin low while idle");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:3] s_axi_bvalid)
        else $error("write response late");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken during response");
    a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken during response");
    c_frame: cover property ($fell(chipSelB));
    c_forced: cover property (monitorSelect > 3'h1 && gainSelect == 3'h0);
    c_write: cover property (s_axi_bvalid);
endmodule
`default_nettype wire

// ---- host_serial_model.sv ----
// host side of the serial result link, one sixteen-bit word per frame
`timescale 1ns/1ps
`default_nettype none
module host_serial_model (
    input wire logic combinedOut,
    output logic serialClk,
    output logic chipSelB
);
    // link clock stands low between frames
    initial begin
        serialClk = 1'b0;
        chipSelB = 1'b1;
    end
    // frames start on the bench's word, never on the combined pin
    task automatic xfer(output logic [15:0] w);
        #7;
        chipSelB = 1'b0;
        #400;
        for (int i = 0; i < 16; i++) begin
            serialClk = 1'b1;
            w = {w[14:0], combinedOut};
            #80;
            serialClk = 1'b0;
            #80;
        end
        chipSelB = 1'b1;
        #200;
    endtask
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// self-checking bench for the gain, rate and calibration register block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic sys_clk = 1'b0, rst_b = 1'b0, rawValid = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [15:0] rawData = 16'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic serialClk, chipSelB, combinedOut, dataReadyB;
    logic [2:0] gainSelect, excitationMagnitude, monitorSelect;
    logic [7:0] gainFactor;
    logic [3:0] rateSelect;
    logic [11:0] rateSps;
    logic [10:0] excitationMicroAmp;
    int failures = 0;
    int tests_run = 0;
    localparam logic [7:0] RST_A [10] = '{8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h28, 8'h40, 8'h44};
    localparam logic [7:0] RST_V [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 8'h50, 8'h00, 8'h01};
    localparam logic [31:0] MAG [8] = '{32'h0, 32'h32, 32'h64, 32'hFA, 32'h1F4, 32'h2EE, 32'h0, 32'h5DC};
    localparam logic [15:0] RAW [4] = '{16'h0064, 16'h7000, 16'hFFFB, 16'h8000};
    localparam logic [23:0] OFF [4] = '{24'h000100, 24'h000000, 24'hFFFF00, 24'h010000};
    localparam logic [23:0] FULLSCALE_CORRECTION_WORD [4] = '{24'h400000, 24'h7FFFFF, 24'h200000, 24'h400000};

    adc_gain_rate_calibration_regs u_dut (.clkEn(1'b1), .s_axi_wstrb(4'hF), .*);
    host_serial_model u_host (.combinedOut(combinedOut), .serialClk(serialClk), .chipSelB(chipSelB));

    initial forever #10 sys_clk = ~sys_clk;

    // ****************************************
    // helpers
    // ****************************************
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            failures++;
            $display("Error %s expected %0h seen %0h", n, e, s);
        end
    endtask
    // handshakes are judged at the falling edge, where the readies have settled
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw, w, b;
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge sys_clk);
            aw = s_axi_awready;
            w = s_axi_wready;
            b = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge sys_clk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end while (!b);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar, v;
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge sys_clk);
            ar = s_axi_arready;
            v = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge sys_clk);
            if (ar) s_axi_arvalid <= 1'b0;
        end while (!v);
        s_axi_rready <= 1'b0;
    endtask
    // decoded outputs may lag the register by a cycle, so settle first
    task automatic wo(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        wr(a, d, r);
        chk("bresp", {30'h0, r}, 32'h0);
        repeat (2) @(negedge sys_clk);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk("rresp", {30'h0, r}, 32'h0);
        chk("rdata", d, e);
    endtask
    task automatic conv(input logic [15:0] raw);
        @(posedge sys_clk);
        rawData <= raw;
        rawValid <= 1'b1;
        @(posedge sys_clk);
        rawValid <= 1'b0;
        repeat (8) @(negedge sys_clk);
    endtask
    function automatic logic [16:0] cal(logic [15:0] r, logic [23:0] o, logic [23:0] f);
        longint p;
        p = ((longint'(signed'(r)) <<< 8) - longint'(signed'(o))) * longint'(f);
        p = p >>> 30;
        if (p > 64'sh7FFF) return 17'h17FFF;
        if (p < -64'sh8000) return 17'h18000;
        return {1'b0, p[15:0]};
    endfunction
    task automatic report_and_stop();
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // ****************************************
    // tests
    // ****************************************
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        logic [15:0] w;
        logic [16:0] e;
        repeat (3) @(posedge sys_clk);
        rst_b <= 1'b1;
        for (int k = 0; k < 10; k++) rdchk(RST_A[k], {24'h0, RST_V[k]});
        for (int k = 0; k < 16; k++) begin
            wo(8'h0C, {25'h0, k[2:0], k[3:0]});
            chk("gainFactor", 32'(gainFactor), 32'h1 << k[2:0]);
            chk("rateSps", 32'(rateSps), (k < 8) ? 32'h5 << k : (k == 8) ? 32'h3E8 : 32'h7D0);
            rdchk(8'h0C, {25'h0, k[2:0], k[3:0]});
        end
        for (int k = 0; k < 8; k++) begin
            wo(8'h28, {24'h0, 4'hA, 1'b0, k[2:0]});
            chk("excitationMicroAmp", 32'(excitationMicroAmp), MAG[k]);
            rdchk(8'h28, {24'h0, 4'h5, 1'b0, k[2:0]});
        end
        wr(8'hFC, 32'h55, r);
        chk("bresp", {30'h0, r}, 32'h2);
        rd(8'hFC, d, r);
        chk("rresp", {30'h0, r}, 32'h2);
        chk("rdata", d, 32'h0);
        wo(8'h0C, 32'h70);
        for (int k = 0; k < 8; k++) begin
            wo(8'h40, {29'h0, k[2:0]});
            chk("gainSelect", 32'(gainSelect), (k > 1) ? 32'h0 : 32'h7);
        end
        rdchk(8'h0C, 32'h70);
        wo(8'h40, 32'h0);
        for (int k = 0; k < 4; k++) begin
            wo(8'h28, {28'h0, k[0], 3'h0});
            for (int j = 0; j < 3; j++) wo(8'h10 + 8'(4 * j), {24'h0, OFF[k][8 * j +: 8]});
            for (int j = 0; j < 3; j++) wo(8'h1C + 8'(4 * j), {24'h0, FULLSCALE_CORRECTION_WORD[k][8 * j +: 8]});
            conv(RAW[k]);
            chk("dataReadyB", 32'(dataReadyB), 32'h0);
            chk("combinedOut", 32'(combinedOut), 32'(!k[0]));
            e = cal(RAW[k], OFF[k], FULLSCALE_CORRECTION_WORD[k]);
            rdchk(8'h48, 32'(e));
            u_host.xfer(w);
            chk("serial", 32'(w), 32'(e[15:0]));
            chk("dataReadyB", 32'(dataReadyB), 32'h1);
        end
        conv(16'h0064);
        chk("combinedOut", 32'(combinedOut), 32'h0);
        wo(8'h44, 32'h0);
        chk("combinedOut", 32'(combinedOut), 32'h1);
        wo(8'h44, 32'h1);
        chk("combinedOut", 32'(combinedOut), 32'h0);
        report_and_stop();
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        report_and_stop();
    end
endmodule
bind adc_gain_rate_calibration_regs adc_cal_monitor u_mon (.*);
`default_nettype wire
